// ==== include/hvc_pkg.sv ====
// Purpose: Shared constants and carriers for the second high-voltage control register
// Assumes: 40 MHz system clock, indirect command/data access
// Notes:   Bits 2 to 0 are held but drive nothing here
package hvc_pkg;

  localparam int unsigned CLK_MHZ          = 40;
  localparam int unsigned SC_BUS_US        = 20;
  localparam int unsigned SC_WAKE_US       = 400;
  // Short must persist longer than the time; these hold the time itself and the filter trips one count past it
  localparam int unsigned SC_BUS_CYC_INT   = SC_BUS_US * CLK_MHZ;
  localparam int unsigned SC_WAKE_CYC_INT  = SC_WAKE_US * CLK_MHZ;
  localparam logic [14:0] SC_BUS_CYC       = 15'(SC_BUS_CYC_INT);
  localparam logic [14:0] SC_WAKE_CYC      = 15'(SC_WAKE_CYC_INT);

  localparam logic [3:0]  CMD_READ_CTRL2   = 4'h1;
  localparam logic [3:0]  CMD_WRITE_CTRL2  = 4'h9;
  localparam logic [7:0]  CTRL2_RESET      = 8'h00;
  localparam logic [11:0] DATA_RESET       = 12'h000;

  localparam int unsigned BIT_ATTEN        = 7;
  localparam int unsigned BIT_TMON         = 6;
  localparam int unsigned BIT_VSHORT       = 5;
  localparam int unsigned BIT_READBACK     = 4;
  localparam int unsigned BIT_REENABLE     = 3;
  localparam int unsigned MON_WAKE_BIT     = 7;
  localparam int unsigned MON_AUX_BIT      = 5;

  localparam int unsigned NPINS            = 3;
  localparam int unsigned PIN_BUS          = 0;
  localparam int unsigned PIN_AUX          = 1;
  localparam int unsigned PIN_WAKE         = 2;

  typedef struct packed {
    logic        atten_en;
    logic        tmon_en;
    logic        vshort_en;
    logic        wake_aux_in_en;
  } hvc_analog_t;

  typedef struct packed {
    logic [NPINS-1:0] short_det;
    logic [1:0]       thermal_off;
  } hvc_fault_t;

endpackage : hvc_pkg

// ==== tb/hvc_properties.sv ====
// Purpose: Port assertions for the second high-voltage control register
// Assumes: Bound onto hvc_control_second
// Notes:   Bus short counted in helper logic
`timescale 1ns/1ps
module hvc_properties (
  // Clock and reset
  input wire logic                 clock,
  input wire logic                 arst_n,
  // Access
  input wire logic                 cmd_valid,
  input wire logic [3:0]           hv_indirect_command,
  input wire logic                 data_we,
  input wire logic [7:0]           data_wdata,
  input wire logic [11:0]          hv_indirect_data,
  // Pins and faults
  input wire logic                 wake_pin,
  input wire logic                 aux_hv_pin,
  input wire hvc_pkg::hvc_fault_t  fault,
  // Outputs
  input wire hvc_pkg::hvc_analog_t analog,
  input wire logic [2:0]           pin_enable,
  input wire logic                 mon_wake,
  input wire logic                 mon_aux,
  input wire logic                 short_irq_pend,
  input wire logic                 hv_irq
);
  logic [15:0] run_r;
  wire         rd = cmd_valid && hv_indirect_command == 4'h1 && !data_we;
  wire         re = cmd_valid && hv_indirect_command == 4'h9 && hv_indirect_data[3];
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) run_r <= 16'h0000;
    else run_r <= fault.short_det[0] ? run_r + 16'h0001 : 16'h0000;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_read_answer: assert property (rd |=> hv_indirect_data[11:4] == {4'h1, analog})
    else $error("read answer wrong");
  a_reenable_zero: assert property (rd |=> !hv_indirect_data[3])
    else $error("re-enable bit read as one");
  a_write_lands: assert property (cmd_valid && hv_indirect_command == 4'h9 |=>
    analog == $past(hv_indirect_data[7:4]))
    else $error("write not applied");
  a_edge_irq: assert property (analog.wake_aux_in_en && $stable(analog.wake_aux_in_en) &&
    ($changed(wake_pin) || $changed(aux_hv_pin)) |=> hv_irq)
    else $error("edge interrupt missing");
  a_mon_level: assert property ($stable(analog.wake_aux_in_en) |-> mon_wake ==
    ($past(wake_pin) && analog.wake_aux_in_en) && mon_aux == ($past(aux_hv_pin) && analog.wake_aux_in_en))
    else $error("monitor level wrong");
  a_bus_trip: assert property (run_r == 16'd810 |-> !pin_enable[0] && short_irq_pend)
    else $error("bus short not tripped");
  a_pend_holds: assert property (short_irq_pend && !re |=> short_irq_pend)
    else $error("pending cleared early");
  a_reenable_pins: assert property (re && fault == '0 |=> pin_enable == 3'b111 && !short_irq_pend)
    else $error("re-enable failed");
  a_off_holds: assert property (!re |=> (pin_enable & ~$past(pin_enable)) == 3'b000)
    else $error("pin came back alone");
  a_irq_pend: assert property (short_irq_pend |-> hv_irq)
    else $error("pending without interrupt");
endmodule : hvc_properties

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the second high-voltage control register
// Assumes: 40 MHz clock, fixed short counts
// Notes:   Random values mixed with fault corner cases
`timescale 1ns/1ps
module testbench;
  logic clock, arst_n, cmd_valid, data_we, wake_pin, aux_hv_pin, mon_wake, mon_aux;
  logic short_irq_pend, hv_irq;
  logic [3:0]  hv_indirect_command;
  logic [7:0]  data_wdata, v;
  logic [11:0] hv_indirect_data;
  logic [2:0]  pin_enable;
  hvc_pkg::hvc_fault_t  fault;
  hvc_pkg::hvc_analog_t analog;
  int n_fail, checked, k, seed, lim;
  hvc_control_second dut_u (.clock, .arst_n, .cmd_valid, .hv_indirect_command, .data_we,
    .data_wdata, .hv_indirect_data, .wake_pin, .aux_hv_pin, .fault, .analog, .pin_enable,
    .mon_wake, .mon_aux, .short_irq_pend, .hv_irq);
  task print_verdict;
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task chk(input logic [11:0] s, input logic [11:0] e);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  function logic [11:0] rd_exp(input logic [7:0] d);
    return {4'h1, d & 8'hf7};
  endfunction : rd_exp
  // Load data, strobe the command, sample once it has landed
  task cmd(input logic [3:0] c, input logic [7:0] d);
    @(posedge clock);
    data_we <= 1'b1;
    data_wdata <= d;
    @(posedge clock);
    data_we <= 1'b0;
    cmd_valid <= 1'b1;
    hv_indirect_command <= c;
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(negedge clock);
  endtask : cmd
  task pins(input logic w, input logic a, input logic en);
    int c;
    c = 0;
    @(posedge clock);
    wake_pin <= w;
    aux_hv_pin <= a;
    repeat (4)
    begin
      @(negedge clock);
      if (hv_irq === 1'b1) c++;
    end
    chk(12'(c), {11'h0, en});
    chk({10'h0, mon_wake, mon_aux}, {10'h0, w & en, a & en});
  endtask : pins
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial
  begin
    repeat (60000) @(posedge clock);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    seed = 32'h903d;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    data_we = 1'b0;
    hv_indirect_command = 4'h0;
    data_wdata = 8'h00;
    wake_pin = 1'b0;
    aux_hv_pin = 1'b0;
    fault = '0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    cmd(4'h1, 8'h5a);
    chk(hv_indirect_data, 12'h100);
    for (k = 0; k < 24; k++)
    begin
      v = (k == 0) ? 8'hff : 8'($random(seed));
      cmd(4'h9, v);
      chk({8'h0, analog}, {8'h0, v[7:4]});
      cmd(4'h3, ~v);
      cmd(4'h1, ~v);
      chk(hv_indirect_data, rd_exp(v));
    end
    cmd(4'h9, 8'h10);
    pins(1'b1, 1'b0, 1'b1);
    pins(1'b1, 1'b1, 1'b1);
    pins(1'b0, 1'b0, 1'b1);
    cmd(4'h9, 8'h00);
    pins(1'b1, 1'b1, 1'b0);
    pins(1'b0, 1'b0, 1'b0);
    for (k = 0; k < 3; k++)
    begin
      lim = (k == 2) ? 16001 : 801;
      @(posedge clock);
      fault.short_det[k] <= 1'b1;
      repeat (lim - 20) @(negedge clock);
      chk({9'h0, pin_enable}, 12'h007);
      repeat (40) @(negedge clock);
      chk({8'h0, short_irq_pend, pin_enable}, {9'h1, 3'b111 ^ (3'b001 << k)});
      @(posedge clock);
      fault.short_det[k] <= 1'b0;
      repeat (5) @(negedge clock);
      chk({10'h0, short_irq_pend, hv_irq}, 12'h003);
      cmd(4'h9, 8'h08);
      chk({8'h0, short_irq_pend, pin_enable}, 12'h007);
    end
    for (k = 0; k < 2; k++)
    begin
      @(posedge clock);
      fault.thermal_off[k] <= 1'b1;
      @(posedge clock);
      fault.thermal_off[k] <= 1'b0;
      repeat (3) @(negedge clock);
      chk({9'h0, pin_enable}, {9'h0, 3'b111 ^ (3'b010 << k)});
      cmd(4'h9, 8'h88);
      chk({9'h0, pin_enable}, 12'h007);
    end
    print_verdict();
  end
endmodule : testbench
bind hvc_control_second hvc_properties chk_u (.clock, .arst_n, .cmd_valid,
  .hv_indirect_command, .data_we, .data_wdata, .hv_indirect_data, .wake_pin, .aux_hv_pin,
  .fault, .analog, .pin_enable, .mon_wake, .mon_aux, .short_irq_pend, .hv_irq);

// ==== verilog/hvc_control_second.sv ====
// Purpose: Second high-voltage control register with indirect access and pin fault handling
// Assumes: Command strobe and data are synchronous to clock
// Notes:   One command per strobe; readback lands in data low byte one cycle later
//
// Overview of operation
// - Eight-bit read/write register, resets to zero
// - Reached only through indirect command and data
// - Bit 7 enables attenuator and its buffer
// - Bit 6 enables temperature monitor into ADC
// - Bit 5 shorts voltage channel for noise test
// - Bit 4 enables wake and aux pin inputs
// - Input edges raise high-voltage interrupt while enabled
// - Pin levels shown in monitor bits 7, 5
// - Writing bit 3 re-enables short-disabled pins
// - Short trips after 20 us, wake 400 us
// - Bit 3 write clears pending short interrupt
// - Command 0x01 reads register into data byte
// - Command 0x09 writes data byte into register
// - Re-enable bit clears itself after write
`timescale 1ns/1ps
module hvc_control_second (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // Indirect command/data access
  input  wire logic                  cmd_valid,
  input  wire logic [3:0]            hv_indirect_command,
  input  wire logic                  data_we,
  input  wire logic [7:0]            data_wdata,
  output logic      [11:0]           hv_indirect_data,
  // Pins and fault sensing
  input  wire logic                  wake_pin,
  input  wire logic                  aux_hv_pin,
  input  wire hvc_pkg::hvc_fault_t   fault,
  // Analog controls
  output hvc_pkg::hvc_analog_t       analog,
  output logic      [hvc_pkg::NPINS-1:0] pin_enable,
  // Status and interrupts
  output logic                       mon_wake,
  output logic                       mon_aux,
  output logic                       short_irq_pend,
  output logic                       hv_irq
);

  typedef struct packed {
    logic [7:0]                  ctrl;
    logic [11:0]                 data;
    logic [hvc_pkg::NPINS-1:0]   pin_off;
    logic [hvc_pkg::NPINS-1:0]   pin_on;
    logic                        short_pend;
    logic                        wake_q;
    logic                        aux_q;
    logic                        mon_wake;
    logic                        mon_aux;
    logic                        irq;
    hvc_pkg::hvc_analog_t        analog;
  } hvc_state_t;

  hvc_state_t st_r;
  hvc_state_t st_nxt;

  logic [hvc_pkg::NPINS-1:0] trip;

  // One persistence filter per pin; the wake pin waits longer
  genvar gi;
  generate
    for (gi = 0; gi < hvc_pkg::NPINS; gi++)
    begin : g_flt
      hvc_short_filter u_flt (
        .clock    (clock),
        .arst_n   (arst_n),
        .short_in (fault.short_det[gi]),
        .limit    ((gi == hvc_pkg::PIN_WAKE) ? hvc_pkg::SC_WAKE_CYC
                                              : hvc_pkg::SC_BUS_CYC),
        .trip     (trip[gi])
      );
    end
  endgenerate

  logic reenable_wr;
  logic edge_seen;
  logic wr_cmd;

  always_comb
  begin
    st_nxt      = st_r;
    wr_cmd      = cmd_valid && (hv_indirect_command == hvc_pkg::CMD_WRITE_CTRL2);
    reenable_wr = wr_cmd && st_r.data[hvc_pkg::BIT_REENABLE];

    if (data_we)
    begin
      st_nxt.data = {4'h0, data_wdata};
    end

    if (wr_cmd)
    begin
      st_nxt.ctrl = st_r.data[7:0];
      st_nxt.ctrl[hvc_pkg::BIT_REENABLE] = 1'b0;
      st_nxt.data[11:8] = hvc_pkg::CMD_WRITE_CTRL2;
    end
    else if (cmd_valid && (hv_indirect_command == hvc_pkg::CMD_READ_CTRL2))
    begin
      st_nxt.data = {hvc_pkg::CMD_READ_CTRL2, st_r.ctrl};
    end

    // Re-enable restores pins and clears the pending short; a new trip wins
    if (reenable_wr)
    begin
      st_nxt.pin_off    = '0;
      st_nxt.short_pend = 1'b0;
    end
    if (fault.thermal_off[0])
      st_nxt.pin_off[hvc_pkg::PIN_AUX] = 1'b1;
    if (fault.thermal_off[1])
      st_nxt.pin_off[hvc_pkg::PIN_WAKE] = 1'b1;
    if (|trip)
    begin
      st_nxt.pin_off    = st_nxt.pin_off | trip;
      st_nxt.short_pend = 1'b1;
    end

    // Registered copy of the enables so the pin outputs come straight from flops
    st_nxt.pin_on = ~st_nxt.pin_off;

    st_nxt.wake_q = wake_pin;
    st_nxt.aux_q  = aux_hv_pin;
    edge_seen = (wake_pin != st_r.wake_q) || (aux_hv_pin != st_r.aux_q);
    st_nxt.irq = (st_r.ctrl[hvc_pkg::BIT_READBACK] && edge_seen) || st_nxt.short_pend;

    st_nxt.mon_wake = st_r.ctrl[hvc_pkg::BIT_READBACK] && wake_pin;
    st_nxt.mon_aux  = st_r.ctrl[hvc_pkg::BIT_READBACK] && aux_hv_pin;

    st_nxt.analog.atten_en       = st_nxt.ctrl[hvc_pkg::BIT_ATTEN];
    st_nxt.analog.tmon_en        = st_nxt.ctrl[hvc_pkg::BIT_TMON];
    st_nxt.analog.vshort_en      = st_nxt.ctrl[hvc_pkg::BIT_VSHORT];
    st_nxt.analog.wake_aux_in_en = st_nxt.ctrl[hvc_pkg::BIT_READBACK];
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r        <= '0;
      st_r.pin_on <= '1;
      st_r.ctrl   <= hvc_pkg::CTRL2_RESET;
      st_r.data <= hvc_pkg::DATA_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Register only reachable through the indirect pair
  assign hv_indirect_data = st_r.data;
  assign analog           = st_r.analog;
  assign pin_enable       = st_r.pin_on;
  assign mon_wake         = st_r.mon_wake;
  assign mon_aux          = st_r.mon_aux;
  assign short_irq_pend   = st_r.short_pend;
  assign hv_irq           = st_r.irq;

endmodule : hvc_control_second

// ==== verilog/hvc_short_filter.sv ====
// Purpose: Persistence filter for one pin's short-circuit indication
// Assumes: short_in synchronous to clock
// Notes:   Trips after the short has lasted longer than limit cycles
`timescale 1ns/1ps
module hvc_short_filter (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Detection
  input  wire logic        short_in,
  input  wire logic [14:0] limit,
  output logic             trip
);

  typedef struct packed {
    logic [14:0] cnt;
    logic        trip;
  } hvc_flt_state_t;

  hvc_flt_state_t st_r;
  hvc_flt_state_t st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.trip = 1'b0;
    if (!short_in)
    begin
      st_nxt.cnt = 15'h0000;
    end
    else if (st_r.cnt < limit)
    begin
      st_nxt.cnt = st_r.cnt + 15'h0001;
    end
    else
    begin
      st_nxt.trip = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign trip = st_r.trip;

endmodule : hvc_short_filter
